//--- core/sbcms_pkg.sv
// Purpose: Shared constants and types for the operating-mode state machine.
// Assumes: One 100 MHz reference clock.
// Notes: Counts are derived from times in microseconds.
package sbcms_pkg;
	localparam int SBCMS_CLK_MHZ = 100;
	localparam int SBCMS_T_RD_US = 10;
	localparam int SBCMS_T_LW_US = 200000;
	localparam int SBCMS_RD_CYC = SBCMS_T_RD_US * SBCMS_CLK_MHZ;
	localparam int SBCMS_LW_CYC = SBCMS_T_LW_US * SBCMS_CLK_MHZ;
	localparam int SBCMS_CNT_W = 32;
	localparam logic [1:0] SBCMS_RST_LIMIT = 2'h3;
	localparam logic [2:0] SBCMS_SEL_NORMAL = 3'h0;
	localparam logic [2:0] SBCMS_SEL_STOP = 3'h1;
	localparam logic [2:0] SBCMS_SEL_SLEEP = 3'h2;
	localparam logic [2:0] SBCMS_SEL_RESET = 3'h4;
	typedef enum logic [5:0] {
		SBCMS_INIT = 6'b00_0001,
		SBCMS_NORMAL = 6'b00_0010,
		SBCMS_STOP = 6'b00_0100,
		SBCMS_SLEEP = 6'b00_1000,
		SBCMS_RESTART = 6'b01_0000,
		SBCMS_FAILSAFE = 6'b10_0000
	} sbcms_mode_t;
	typedef struct packed {
		logic spi_cmd;
		logic [2:0] mode_sel;
		logic miss_count_select;
		logic reset_limit;
		logic wd_trigger;
	} sbcms_host_t;
	typedef struct packed {
		logic main_ok;
		logic vs_uv_to;
		logic por;
		logic thermal_shutdown_level_two;
		logic main_short;
		logic overtemp;
		logic wake_any;
	} sbcms_mon_t;
endpackage

//--- core/sbcms_sync.sv
// Purpose: Two-stage synchroniser for one asynchronous level.
// Assumes: Single clock domain.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ps
module sbcms_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire logic d,
	output logic q
);
	typedef struct packed {
		logic s1;
		logic s2;
	} sbcms_sync_t;
	sbcms_sync_t st_r;
	sbcms_sync_t st_nxt;
	always_comb begin
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign q = st_r.s2;
endmodule

//--- core/sbcms_timer.sv
// Purpose: Loadable down-counter that flags expiry.
// Assumes: Load wins over run.
// Notes: Done stays high at zero until reloaded.
`timescale 1ns/1ps
module sbcms_timer
	import sbcms_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic load,
	input wire logic [SBCMS_CNT_W-1:0] value,
	input wire logic run,
	output logic done
);
	typedef struct packed {
		logic [SBCMS_CNT_W-1:0] cnt;
	} sbcms_tmr_t;
	sbcms_tmr_t st_r;
	sbcms_tmr_t st_nxt;
	always_comb begin
		st_nxt = st_r;
		if (load) begin
			st_nxt.cnt = value;
		end else if (run && st_r.cnt != '0) begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign done = (st_r.cnt == '0);
endmodule

//--- core/sbcms_top.sv
// Purpose: Operating-mode state machine with strap capture and reset timing.
// Assumes: SPI frames decoded outside; events arrive as one-cycle pulses on REF_CLK.
// Notes: Monitor levels and the strap are asynchronous; all but wake_any are synchronised here.
// Summary of operation
// - Six modes held one-hot; exactly one active at any time.
// - Power-on or software reset command enters init mode.
// - Restart leaves for normal alone after failure gone and reset delay.
// - Critical failure enters fail-safe, main supply off, exit on wake without overtemp.
// - Development mode allows all modes but freezes the watchdog.
// - Strap low during init selects development configuration.
// - All control arrives through decoded 16-bit SPI commands.
// - Mode follows host select bits; bits cleared passing through restart.
// - Miss-count state 1: first missed trigger fails outputs, enters restart.
// - Miss-count state 0: second missed trigger fails outputs, enters restart.
// - Host selects configuration 1 or 3 with the miss-count select bit.
// - Strap pin is an input with pull-up during init and is sampled.
// - After main supply good, strap watched for reset delay, then watchdog starts.
// - Any SPI command in init mode after the reset delay moves to normal mode.
// - No trigger in long open window flags failure, restart, one reset; in miss-count state 0 the first miss only flags failure.
// - With reset limit set, no resets after three consecutive watchdog resets.
// - With reset limit clear, every missed trigger gives a reset in miss-count state 1, every second consecutive one in state 0.
// - Wake events in init mode are discarded.
// - No undervoltage flag or fail outputs while both supplies are low at power-up.
// - Reset output low below threshold, released one reset delay after it.
// - Stop to sleep request sets SPI error and enters restart.
`timescale 1ns/1ps
module sbcms_top
	import sbcms_pkg::*;
#(
	parameter logic [SBCMS_CNT_W-1:0] RESET_DELAY_CYC = SBCMS_CNT_W'(SBCMS_RD_CYC),
	parameter logic [SBCMS_CNT_W-1:0] LONG_WINDOW_CYC = SBCMS_CNT_W'(SBCMS_LW_CYC)
)
(
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire sbcms_host_t HOST,
	input wire sbcms_mon_t MON,
	input wire logic FAIL_OUT_THREE_STRAP_PIN_IN,
	output logic FAIL_OUT_THREE_STRAP_PIN_OUT,
	output logic FAIL_OUT_THREE_STRAP_PIN_OE,
	output logic FAIL_OUT_THREE_STRAP_PULLUP_EN,
	output sbcms_mode_t MODE,
	output logic [2:0] MODE_SEL_READBACK,
	output logic RESET_OUTPUT_N,
	output logic MAIN_SUPPLY_EN,
	output logic FAIL_OUTPUTS,
	output logic MAIN_SUPPLY_UNDERVOLTAGE_FLAG,
	output logic WATCHDOG_FAIL_FLAG,
	output logic SPI_ERROR_FLAG,
	output logic DEVELOPMENT_MODE,
	output logic WAKE_EVENT_FLAG
);
	typedef struct packed {
		sbcms_mode_t mode;
		logic [2:0] mode_sel;
		logic dev_mode;
		logic strap_done;
		logic rst_n;
		logic wd_run;
		logic wd_load;
		logic rd_load;
		logic miss_once;
		logic [1:0] wd_resets;
		logic fail_out;
		logic uv_flag;
		logic wd_fail;
		logic spi_err;
		logic wake_flag;
		logic main_en;
		logic main_ok_d;
	} sbcms_state_t;
	sbcms_state_t st_r;
	sbcms_state_t st_nxt;
	logic strap_s;
	logic main_ok_s;
	logic vs_uv_s;
	logic por_s;
	logic thermal_shutdown_level_two_s;
	logic short_s;
	logic otemp_s;
	logic rd_done;
	logic wd_done;
	logic wd_expire;
	logic [2:0] req;
	logic powerup_low;
	sbcms_sync u_sync_strap (
		.clk(REF_CLK),
		.rstn(RSTN),
		.d(FAIL_OUT_THREE_STRAP_PIN_IN),
		.q(strap_s)
	);
	sbcms_sync u_sync_ok (
		.clk(REF_CLK),
		.rstn(RSTN),
		.d(MON.main_ok),
		.q(main_ok_s)
	);
	sbcms_sync u_sync_vs (
		.clk(REF_CLK),
		.rstn(RSTN),
		.d(MON.vs_uv_to),
		.q(vs_uv_s)
	);
	sbcms_sync u_sync_por (
		.clk(REF_CLK),
		.rstn(RSTN),
		.d(MON.por),
		.q(por_s)
	);
	sbcms_sync u_sync_tsd (
		.clk(REF_CLK),
		.rstn(RSTN),
		.d(MON.thermal_shutdown_level_two),
		.q(thermal_shutdown_level_two_s)
	);
	sbcms_sync u_sync_sc (
		.clk(REF_CLK),
		.rstn(RSTN),
		.d(MON.main_short),
		.q(short_s)
	);
	sbcms_sync u_sync_ot (
		.clk(REF_CLK),
		.rstn(RSTN),
		.d(MON.overtemp),
		.q(otemp_s)
	);
	sbcms_timer u_rd_timer (
		.clk(REF_CLK),
		.rstn(RSTN),
		.load(st_r.rd_load),
		.value(RESET_DELAY_CYC),
		.run(main_ok_s),
		.done(rd_done)
	);
	sbcms_timer u_wd_timer (
		.clk(REF_CLK),
		.rstn(RSTN),
		.load(st_r.wd_load),
		.value(LONG_WINDOW_CYC),
		.run(st_r.wd_run && !st_r.dev_mode),
		.done(wd_done)
	);
	assign wd_expire = st_r.wd_run && !st_r.dev_mode && !st_r.wd_load && wd_done;
	assign req = HOST.mode_sel;
	assign powerup_low = (st_r.mode == SBCMS_INIT) && !main_ok_s && !vs_uv_s;
	always_comb begin
		st_nxt = st_r;
		st_nxt.wd_load = 1'b0;
		st_nxt.rd_load = 1'b0;
		st_nxt.main_ok_d = main_ok_s;
		if (!main_ok_s && st_r.main_ok_d && st_r.main_en && !(st_r.mode == SBCMS_INIT && !vs_uv_s)) begin
			st_nxt.uv_flag = 1'b1;
		end
		if (!main_ok_s) begin
			st_nxt.rst_n = 1'b0;
			st_nxt.rd_load = 1'b1;
		end
		if (HOST.wd_trigger && st_r.wd_run) begin
			st_nxt.wd_load = 1'b1;
			st_nxt.miss_once = 1'b0;
			st_nxt.wd_resets = 2'h0;
		end
		case (st_r.mode)
			SBCMS_INIT: begin
				st_nxt.wake_flag = 1'b0;
				if (!st_r.strap_done && main_ok_s) begin
					st_nxt.dev_mode = !strap_s;
					if (rd_done && !st_r.rd_load) begin
						st_nxt.strap_done = 1'b1;
						st_nxt.rst_n = 1'b1;
						st_nxt.wd_run = 1'b1;
						st_nxt.wd_load = 1'b1;
					end
				end
				if (HOST.spi_cmd && st_r.strap_done) begin
					st_nxt.mode = SBCMS_NORMAL;
				end
			end
			SBCMS_NORMAL, SBCMS_STOP: begin
				if (HOST.spi_cmd) begin
					st_nxt.mode_sel = req;
					if (req == SBCMS_SEL_NORMAL) begin
						st_nxt.mode = SBCMS_NORMAL;
					end else if (req == SBCMS_SEL_STOP) begin
						st_nxt.mode = SBCMS_STOP;
					end else if (req == SBCMS_SEL_SLEEP && st_r.mode == SBCMS_STOP) begin
						st_nxt.spi_err = 1'b1;
						st_nxt.mode = SBCMS_RESTART;
						st_nxt.rst_n = 1'b0;
						st_nxt.rd_load = 1'b1;
					end else if (req == SBCMS_SEL_SLEEP) begin
						st_nxt.mode = SBCMS_SLEEP;
						st_nxt.rst_n = 1'b0;
						st_nxt.main_en = 1'b0;
						st_nxt.wd_run = 1'b0;
					end
				end
				if (!main_ok_s) begin
					st_nxt.mode = SBCMS_RESTART;
				end
				if (wd_expire) begin
					st_nxt.wd_load = 1'b1;
					st_nxt.wd_fail = 1'b1;
					if (!HOST.miss_count_select && !st_r.miss_once) begin
						st_nxt.miss_once = 1'b1;
					end else if (HOST.reset_limit && st_r.wd_resets == SBCMS_RST_LIMIT) begin
						st_nxt.miss_once = 1'b0;
					end else begin
						st_nxt.miss_once = 1'b0;
						st_nxt.fail_out = 1'b1;
						st_nxt.mode = SBCMS_RESTART;
						st_nxt.rst_n = 1'b0;
						st_nxt.rd_load = 1'b1;
						if (st_r.wd_resets != SBCMS_RST_LIMIT) begin
							st_nxt.wd_resets = st_r.wd_resets + 2'h1;
						end
					end
				end
			end
			SBCMS_SLEEP: begin
				if (MON.wake_any) begin
					st_nxt.wake_flag = 1'b1;
					st_nxt.main_en = 1'b1;
					st_nxt.mode = SBCMS_RESTART;
					st_nxt.rd_load = 1'b1;
				end
			end
			SBCMS_RESTART: begin
				st_nxt.mode_sel = SBCMS_SEL_NORMAL;
				st_nxt.rst_n = 1'b0;
				if (main_ok_s && rd_done && !st_r.rd_load) begin
					st_nxt.mode = SBCMS_NORMAL;
					st_nxt.rst_n = 1'b1;
					st_nxt.wd_run = 1'b1;
					st_nxt.wd_load = 1'b1;
				end
			end
			SBCMS_FAILSAFE: begin
				st_nxt.rst_n = 1'b0;
				if (MON.wake_any && !otemp_s) begin
					st_nxt.wake_flag = 1'b1;
					st_nxt.main_en = 1'b1;
					st_nxt.mode = SBCMS_RESTART;
					st_nxt.rd_load = 1'b1;
				end
			end
			default: begin
				st_nxt.mode = SBCMS_INIT;
			end
		endcase
		if ((thermal_shutdown_level_two_s || short_s) && st_r.mode != SBCMS_FAILSAFE) begin
			st_nxt.mode = SBCMS_FAILSAFE;
			st_nxt.main_en = 1'b0;
			if (!powerup_low) begin
				st_nxt.fail_out = 1'b1;
			end
			st_nxt.rst_n = 1'b0;
			st_nxt.wd_run = 1'b0;
		end
		if (por_s || (HOST.spi_cmd && req == SBCMS_SEL_RESET && st_r.mode != SBCMS_INIT)) begin
			st_nxt.mode = SBCMS_INIT;
			st_nxt.mode_sel = SBCMS_SEL_NORMAL;
			st_nxt.strap_done = 1'b0;
			st_nxt.rst_n = 1'b0;
			st_nxt.wd_run = 1'b0;
			st_nxt.rd_load = 1'b1;
			st_nxt.main_en = 1'b1;
			st_nxt.miss_once = 1'b0;
			st_nxt.wd_resets = 2'h0;
			st_nxt.wake_flag = 1'b0;
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			st_r <= '{
				mode: SBCMS_INIT,
				mode_sel: SBCMS_SEL_NORMAL,
				rd_load: 1'b1,
				main_en: 1'b1,
				default: '0
			};
		end else begin
			st_r <= st_nxt;
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			MODE <= SBCMS_INIT;
			MODE_SEL_READBACK <= SBCMS_SEL_NORMAL;
			RESET_OUTPUT_N <= 1'b0;
			MAIN_SUPPLY_EN <= 1'b1;
			FAIL_OUTPUTS <= 1'b0;
			MAIN_SUPPLY_UNDERVOLTAGE_FLAG <= 1'b0;
			WATCHDOG_FAIL_FLAG <= 1'b0;
			SPI_ERROR_FLAG <= 1'b0;
			DEVELOPMENT_MODE <= 1'b0;
			WAKE_EVENT_FLAG <= 1'b0;
			FAIL_OUT_THREE_STRAP_PIN_OUT <= 1'b0;
			FAIL_OUT_THREE_STRAP_PIN_OE <= 1'b0;
			FAIL_OUT_THREE_STRAP_PULLUP_EN <= 1'b1;
		end else begin
			MODE <= st_nxt.mode;
			MODE_SEL_READBACK <= st_nxt.mode_sel;
			RESET_OUTPUT_N <= st_nxt.rst_n;
			MAIN_SUPPLY_EN <= st_nxt.main_en;
			FAIL_OUTPUTS <= st_nxt.fail_out;
			MAIN_SUPPLY_UNDERVOLTAGE_FLAG <= st_nxt.uv_flag;
			WATCHDOG_FAIL_FLAG <= st_nxt.wd_fail;
			SPI_ERROR_FLAG <= st_nxt.spi_err;
			DEVELOPMENT_MODE <= st_nxt.dev_mode;
			WAKE_EVENT_FLAG <= st_nxt.wake_flag;
			FAIL_OUT_THREE_STRAP_PIN_OUT <= 1'b0;
			FAIL_OUT_THREE_STRAP_PIN_OE <= st_nxt.fail_out && (st_nxt.mode != SBCMS_INIT);
			FAIL_OUT_THREE_STRAP_PULLUP_EN <= (st_nxt.mode == SBCMS_INIT);
		end
	end
endmodule

//--- verification/sbcms_chk.sv
// Purpose: Port checks for the mode state machine.
// Assumes: Monitor levels are held for several cycles.
// Notes: Bound to the top module.
`timescale 1ns/1ps
module sbcms_chk
	import sbcms_pkg::*;
#(
	parameter logic [SBCMS_CNT_W-1:0] RESET_DELAY_CYC = 32'h0000_03e8
)
(
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire sbcms_host_t HOST,
	input wire sbcms_mon_t MON,
	input wire sbcms_mode_t MODE,
	input wire logic RESET_OUTPUT_N,
	input wire logic MAIN_SUPPLY_EN,
	input wire logic SPI_ERROR_FLAG,
	input wire logic WAKE_EVENT_FLAG
);
	int rc_r;
	int oc_r;
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RSTN);
	always_ff @(posedge REF_CLK) begin
		rc_r <= (MODE == SBCMS_RESTART) ? rc_r + 1 : 0;
		oc_r <= (MODE == SBCMS_INIT && MON.main_ok) ? oc_r + 1 : 0;
	end
	sequence s_stop_sleep;
		MODE == SBCMS_STOP && HOST.spi_cmd && HOST.mode_sel == SBCMS_SEL_SLEEP;
	endsequence
	sequence s_refused;
		MODE == SBCMS_RESTART && SPI_ERROR_FLAG;
	endsequence
	chk_one_hot: assert property ($onehot(MODE))
		else $error("mode not one-hot");
	chk_init_cmd: assert property (
		MODE == SBCMS_INIT && RESET_OUTPUT_N && HOST.spi_cmd && HOST.mode_sel != SBCMS_SEL_RESET
		|=> MODE == SBCMS_NORMAL) else $error("init command ignored");
	chk_refuse: assert property (s_stop_sleep |=> s_refused)
		else $error("stop to sleep not refused");
	chk_rst_low: assert property (MODE == SBCMS_RESTART |-> !RESET_OUTPUT_N)
		else $error("reset released in restart");
	chk_rst_len: assert property (MODE == SBCMS_RESTART |-> rc_r <= RESET_DELAY_CYC + 8)
		else $error("restart too long");
	chk_fs_supply: assert property (MODE == SBCMS_FAILSAFE |-> !MAIN_SUPPLY_EN)
		else $error("supply on in fail-safe");
	chk_fs_entry: assert property (
		MON.thermal_shutdown_level_two && MODE == SBCMS_NORMAL |-> ##[1:4] MODE == SBCMS_FAILSAFE) else $error("no fail-safe");
	chk_init_wake: assert property (MODE == SBCMS_INIT |-> !WAKE_EVENT_FLAG)
		else $error("wake kept in init");
	chk_rst_delay: assert property ($rose(RESET_OUTPUT_N) && MODE == SBCMS_INIT
		|-> oc_r >= RESET_DELAY_CYC - 2 && oc_r <= RESET_DELAY_CYC + 8) else $error("reset delay off");
endmodule
bind sbcms_top sbcms_chk #(.RESET_DELAY_CYC(RESET_DELAY_CYC)) u_chk (.REF_CLK, .RSTN, .HOST, .MON, .MODE,
	.RESET_OUTPUT_N, .MAIN_SUPPLY_EN, .SPI_ERROR_FLAG, .WAKE_EVENT_FLAG);

//--- verification/sbcms_mcu_model.sv
// Purpose: Host controller model sending frames and triggers.
// Assumes: Requests are registered and arrive one cycle late.
// Notes: Idle select lines carry the inverted select so stale values are not trusted.
`timescale 1ns/1ps
module sbcms_mcu_model
	import sbcms_pkg::*;
(
	input wire logic clk,
	input wire logic cmd,
	input wire logic [2:0] sel,
	input wire logic kick,
	input wire logic cfg1,
	input wire logic limit,
	output sbcms_host_t host
);
	always @(posedge clk) begin
		host.spi_cmd <= cmd;
		host.mode_sel <= cmd ? sel : ~sel;
		host.wd_trigger <= kick;
		host.miss_count_select <= cfg1;
		host.reset_limit <= limit;
	end
endmodule

//--- verification/sbc_mode_state_machine_bench.sv
// Purpose: Self-checking bench for the mode state machine.
// Assumes: Short reset delay and window counts.
// Notes: Every mode change must match the oldest expected mode.
`timescale 1ns/1ps
module sbc_mode_state_machine_bench
	import sbcms_pkg::*;
;
	localparam int RD = 20;
	localparam int LW = 100;
	logic ref_clk = 0;
	logic rstn = 0;
	logic cmd = 0;
	logic [2:0] sel = 0;
	logic kick = 0;
	logic kick_en = 0;
	logic cfg1 = 1;
	logic limit = 0;
	logic strap = 1;
	sbcms_mon_t mon = '0;
	sbcms_host_t host;
	sbcms_mode_t mode;
	sbcms_mode_t prev;
	sbcms_mode_t exp_q[$];
	logic [2:0] rdbk;
	logic rst_n, sup_en, fail, uv, wd_fail, spi_err, dev, wake_f, pull, pin_o, pin_oe;
	wire logic pin_lv;
	integer seed = 32'h737e_19c9;
	logic [31:0] r;
	logic [31:0] kr;
	int error_cnt = 0;
	int n_compared = 0;
	int n;
	assign pin_lv = pin_oe ? pin_o : strap;
	initial forever #5 ref_clk = ~ref_clk;
	sbcms_mcu_model u_mcu (.clk(ref_clk), .cmd(cmd), .sel(sel), .kick(kick), .cfg1(cfg1), .limit(limit),
		.host(host));
	sbcms_top #(.RESET_DELAY_CYC(32'(RD)), .LONG_WINDOW_CYC(32'(LW))) dut (.REF_CLK(ref_clk), .RSTN(rstn),
		.HOST(host), .MON(mon), .FAIL_OUT_THREE_STRAP_PIN_IN(pin_lv), .FAIL_OUT_THREE_STRAP_PIN_OUT(pin_o),
		.FAIL_OUT_THREE_STRAP_PIN_OE(pin_oe), .FAIL_OUT_THREE_STRAP_PULLUP_EN(pull), .MODE(mode),
		.MODE_SEL_READBACK(rdbk), .RESET_OUTPUT_N(rst_n), .MAIN_SUPPLY_EN(sup_en), .FAIL_OUTPUTS(fail),
		.MAIN_SUPPLY_UNDERVOLTAGE_FLAG(uv), .WATCHDOG_FAIL_FLAG(wd_fail), .SPI_ERROR_FLAG(spi_err),
		.DEVELOPMENT_MODE(dev), .WAKE_EVENT_FLAG(wake_f));
	task automatic end_of_test();
		$display("Compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cmp_mode(sbcms_mode_t e, sbcms_mode_t g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR mode expected %h seen %h", e, g);
		end
	endtask
	task automatic cmp_val(string nm, logic [5:0] e, logic [5:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(int k);
		repeat (k) @(posedge ref_clk);
	endtask
	task automatic ex(sbcms_mode_t a);
		exp_q.push_back(a);
	endtask
	task automatic rn();
		ex(SBCMS_RESTART);
		ex(SBCMS_NORMAL);
	endtask
	task automatic send(logic [2:0] s);
		@(posedge ref_clk);
		cmd <= 1;
		sel <= s;
		@(posedge ref_clk);
		cmd <= 0;
	endtask
	task automatic wake();
		@(posedge ref_clk);
		mon.wake_any <= 1;
		@(posedge ref_clk);
		mon.wake_any <= 0;
	endtask
	task automatic wait_mode(sbcms_mode_t m);
		for (n = 0; n < 400 && mode !== m; n++)
			@(negedge ref_clk);
		if (mode !== m) begin
			cmp_mode(m, mode);
			end_of_test();
		end
		@(posedge ref_clk);
	endtask
	task automatic wait_hi(ref logic s);
		for (n = 0; n < 400 && s !== 1'b1; n++)
			@(negedge ref_clk);
		if (s !== 1'b1) begin
			cmp_val("wait", 1, s);
			end_of_test();
		end
		@(posedge ref_clk);
	endtask
	task automatic do_reset(logic s);
		@(posedge ref_clk);
		rstn <= 0;
		strap <= s;
		mon <= '0;
		kick_en <= 0;
		exp_q.delete();
		tick(4);
		rstn <= 1;
		@(negedge ref_clk);
		cmp_val("mode", SBCMS_INIT, mode);
		cmp_val("pullup", 1, pull);
		@(posedge ref_clk);
		mon.main_ok <= 1;
		wait_hi(rst_n);
		cmp_val("delay", 1, n >= RD);
		cmp_val("uv", 0, {uv, fail});
	endtask
	always @(posedge ref_clk) begin
		kr = $random(seed);
		kick <= kick_en && kr[2:0] == 3'h0;
	end
	always @(negedge ref_clk) begin
		if (rstn !== 1'b1)
			prev = mode;
		else if (mode !== prev) begin
			prev = mode;
			cmp_mode(exp_q.size() ? exp_q.pop_front() : sbcms_mode_t'(6'h00), mode);
		end
	end
	initial begin
		do_reset(1);
		wake();
		tick(2);
		cmp_val("wake", 0, wake_f);
		kick_en <= 1;
		r = $random(seed);
		ex(SBCMS_NORMAL);
		send({1'b0, r[1:0]});
		wait_mode(SBCMS_NORMAL);
		ex(SBCMS_STOP);
		send(SBCMS_SEL_STOP);
		wait_mode(SBCMS_STOP);
		rn();
		send(SBCMS_SEL_SLEEP);
		wait_mode(SBCMS_NORMAL);
		cmp_val("spi_err", 1, spi_err);
		cmp_val("readback", SBCMS_SEL_NORMAL, rdbk);
		ex(SBCMS_SLEEP);
		send(SBCMS_SEL_SLEEP);
		wait_mode(SBCMS_SLEEP);
		rn();
		wake();
		wait_mode(SBCMS_NORMAL);
		cmp_val("wake", 1, wake_f);
		ex(SBCMS_FAILSAFE);
		mon.thermal_shutdown_level_two <= 1;
		mon.overtemp <= 1;
		wait_mode(SBCMS_FAILSAFE);
		cmp_val("supply", 0, sup_en);
		mon.thermal_shutdown_level_two <= 0;
		wake();
		tick(8);
		mon.overtemp <= 0;
		tick(4);
		rn();
		wake();
		wait_mode(SBCMS_NORMAL);
		kick_en <= 0;
		rn();
		rn();
		wait_mode(SBCMS_RESTART);
		cmp_val("fail", 3, {wd_fail, fail});
		cmp_val("pin", 2, {pin_oe, pin_o});
		wait_mode(SBCMS_NORMAL);
		wait_mode(SBCMS_RESTART);
		wait_mode(SBCMS_NORMAL);
		ex(SBCMS_INIT);
		send(SBCMS_SEL_RESET);
		wait_mode(SBCMS_INIT);
		do_reset(1);
		cfg1 <= 0;
		ex(SBCMS_NORMAL);
		send(0);
		wait_hi(wd_fail);
		cmp_val("fail", 0, fail);
		rn();
		wait_mode(SBCMS_RESTART);
		cmp_val("fail", 1, fail);
		do_reset(1);
		cfg1 <= 1;
		limit <= 1;
		ex(SBCMS_NORMAL);
		send(1);
		repeat (3) rn();
		tick(800);
		cmp_val("queue", 0, 6'(exp_q.size()));
		do_reset(0);
		cmp_val("dev", 1, dev);
		ex(SBCMS_NORMAL);
		send(3);
		ex(SBCMS_STOP);
		send(SBCMS_SEL_STOP);
		tick(400);
		cmp_val("fail", 0, {wd_fail, fail});
		end_of_test();
	end
endmodule
